// ===== mfd_defines.vh
// Constants for the multi-function input decoder
`ifndef MFD_DEFINES_VH
`define MFD_DEFINES_VH
// Register byte offsets
`define MFD_OFS_IN_STATE    12'h000
`define MFD_OFS_OUT_STATE   12'h004
`define MFD_OFS_FUNC_SEL0   12'h008
`define MFD_OFS_FUNC_SEL1   12'h00C
`define MFD_OFS_CONFIG      12'h010
`define MFD_OFS_STATUS      12'h014
`define MFD_OFS_COMMAND     12'h018
`define MFD_OFS_FILTER      12'h01C
// Terminal input count and function selector width
`define MFD_NUM_IN          9
`define MFD_NUM_PROG        6
`define MFD_FSEL_W          6
// Function codes assigned to programmable terminals
`define MFD_FN_SPEED_L      6'h00
`define MFD_FN_SPEED_M      6'h01
`define MFD_FN_SPEED_H      6'h02
`define MFD_FN_TRIP_A       6'h0D
`define MFD_FN_TRIP_B       6'h0E
`define MFD_FN_ICLEAR       6'h0F
`define MFD_FN_OPEN_LOOP    6'h10
`define MFD_FN_LOCAL        6'h11
`define MFD_FN_AHOLD        6'h12
`define MFD_FN_RFREEZE      6'h13
`define MFD_FN_PGAIN2       6'h14
`define MFD_FN_SEQ_L        6'h15
`define MFD_FN_SEQ_M        6'h16
`define MFD_FN_SEQ_H        6'h17
`define MFD_FN_MANUAL       6'h18
`define MFD_FN_GO_STEP      6'h19
`define MFD_FN_HOLD_STEP    6'h1A
`define MFD_FN_TRV_LO       6'h1B
`define MFD_FN_TRV_HI       6'h1C
`define MFD_FN_SPEED_X      6'h21
`define MFD_FN_RESET        6'h22
`define MFD_FN_HALT         6'h23
`define MFD_FN_INCH         6'h24
`define MFD_FN_FWD          6'h25
`define MFD_FN_REV          6'h26
`define MFD_FN_ANA_CHG      6'h27
`define MFD_FN_PREEXC       6'h28
`define MFD_FN_SPD_TRQ      6'h29
`define MFD_FN_ASR_PPI      6'h2A
`define MFD_FN_NONE         6'h3F
// Config register fields
`define MFD_CFG_ANALOG_REF  0
`define MFD_CFG_VECTOR      1
`define MFD_CFG_AUTO_B      2
`define MFD_CFG_AUTO_EN     3
`define MFD_CFG_TRAVERSE    4
// Status register fields
`define MFD_ST_TRIP         0
`define MFD_ST_HALT         1
`define MFD_ST_RUNNING      2
// Command register fields
`define MFD_CMD_CLR_TRIP    0
// Filter timing
`define MFD_FILT_UNIT_NS    500000
`define MFD_CLK_NS          25
`define MFD_FILT_RST        8'h0A
// Sequence layout
`define MFD_SEQ_STEPS       8
`endif

// ===== mfd_input_filter.v
// Synchroniser and debounce filter for one terminal input
module mfd_input_filter #(
  parameter UNIT_CYC = 20000
) (
  input  wire       clk_in,
  input  wire       nrst_in,
  input  wire       tick_in,
  input  wire [7:0] filt_in,
  input  wire       pin_in,
  output wire       level_out
);
  reg       s1_q;
  reg       s2_q;
  reg       s3_q;
  reg [7:0] cnt_q;
  reg       level_q;

  // Three-stage synchroniser; second and third stages decide
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Accept a new level only after it stands filt_in half-ms ticks
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      cnt_q   <= 8'h00;
      level_q <= 1'b0;
    end else if (s2_q != s3_q || s3_q == level_q) begin
      cnt_q <= 8'h00;
    end else if (tick_in) begin
      if (cnt_q + 8'h01 >= filt_in) begin
        level_q <= s3_q;
        cnt_q   <= 8'h00;
      end else begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end

  assign level_out = level_q;
endmodule

// ===== mfd_apb_regs.v
// APB slave holding the decoder's software registers
`include "mfd_defines.vh"
module mfd_apb_regs (
  input  wire        clk_in,
  input  wire        nrst_in,
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [11:0] paddr_in,
  input  wire [31:0] pwdata_in,
  input  wire [8:0]  in_state_in,
  input  wire [3:0]  out_state_in,
  input  wire [2:0]  status_in,
  output reg  [31:0] prdata_out,
  output reg         pslverr_out,
  output reg  [35:0] func_sel_out,
  output reg  [4:0]  config_out,
  output reg  [7:0]  filter_out,
  output reg         clr_trip_out
);
  wire acc_wr;
  reg  hit;
  reg  [31:0] rd;

  assign acc_wr = psel_in & penable_in & pwrite_in;

  // Read mux and address decode
  always @* begin
    hit = 1'b1;
    rd  = 32'h0000_0000;
    case (paddr_in)
      `MFD_OFS_IN_STATE:  rd = {23'h0, in_state_in};
      `MFD_OFS_OUT_STATE: rd = {28'h0, out_state_in};
      `MFD_OFS_FUNC_SEL0: rd = {14'h0, func_sel_out[17:0]};
      `MFD_OFS_FUNC_SEL1: rd = {14'h0, func_sel_out[35:18]};
      `MFD_OFS_CONFIG:    rd = {27'h0, config_out};
      `MFD_OFS_STATUS:    rd = {29'h0, status_in};
      `MFD_OFS_COMMAND:   rd = 32'h0000_0000;
      `MFD_OFS_FILTER:    rd = {24'h0, filter_out};
      default:            hit = 1'b0;
    endcase
  end

  // Writes and registered read data; zero-wait-state slave
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      func_sel_out <= {6{`MFD_FN_NONE}};
      config_out   <= 5'h00;
      filter_out   <= `MFD_FILT_RST;
      clr_trip_out <= 1'b0;
      prdata_out   <= 32'h0000_0000;
      pslverr_out  <= 1'b0;
    end else begin
      clr_trip_out <= 1'b0;
      pslverr_out  <= psel_in & ~penable_in & ~hit;
      if (psel_in & ~penable_in & ~pwrite_in)
        prdata_out <= rd;
      if (acc_wr & hit) begin
        case (paddr_in)
          `MFD_OFS_FUNC_SEL0: func_sel_out[17:0]  <= pwdata_in[17:0];
          `MFD_OFS_FUNC_SEL1: func_sel_out[35:18] <= pwdata_in[17:0];
          `MFD_OFS_CONFIG:    config_out          <= pwdata_in[4:0];
          `MFD_OFS_FILTER:    filter_out          <= pwdata_in[7:0];
          `MFD_OFS_COMMAND:   clr_trip_out        <= pwdata_in[`MFD_CMD_CLR_TRIP];
          default:            config_out          <= config_out;
        endcase
      end
    end
  end
endmodule

// ===== mfd_decoder.v
// Multi-function control terminal decoder with APB status registers
//
// Design decisions made here: the register addresses and the APB register port.
`include "mfd_defines.vh"
module mfd_decoder #(
  parameter UNIT_CYC = (`MFD_FILT_UNIT_NS + `MFD_CLK_NS - 1) / `MFD_CLK_NS
) (
  input  wire        clk_in,
  input  wire        nrst_in,
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [11:0] paddr_in,
  input  wire [31:0] pwdata_in,
  output wire [31:0] prdata_out,
  output wire        pready_out,
  output wire        pslverr_out,
  input  wire [5:0]  prog_in,
  input  wire        reverse_run_in,
  input  wire        forward_run_in,
  input  wire        inch_in,
  input  wire        fault_reset_in,
  input  wire        emergency_halt_in,
  input  wire [3:0]  out_pins_in,
  input  wire        motor_running_in,
  input  wire        seq_step_done_in,
  output reg         trip_out,
  output reg         power_enable_out,
  output reg         integrator_clear_out,
  output reg         open_loop_out,
  output reg         local_override_out,
  output reg         freq_hold_out,
  output reg         ramp_freeze_out,
  output reg         alternate_prop_gain_out,
  output reg  [2:0]  sequence_out,
  output reg  [2:0]  seq_step_out,
  output reg         seq_active_out,
  output reg         manual_mode_out,
  output reg         step_hold_out,
  output reg         traverse_negative_offset_out,
  output reg         traverse_positive_offset_out,
  output reg         run_forward_out,
  output reg         run_reverse_out,
  output reg         inch_out,
  output reg         current_ref_sel_out,
  output reg         pre_excite_out,
  output reg         torque_mode_out,
  output reg         speed_reg_p_only_out,
  output reg  [3:0]  step_index_out
);
  wire [35:0] func_sel;
  wire [4:0]  cfg;
  wire [7:0]  filt;
  wire        clr_trip;
  wire [8:0]  pins;
  wire [8:0]  lvl;
  reg  [8:0]  in_state_q;
  reg  [3:0]  out_state_q;
  reg  [15:0] div_q;
  reg         tick_q;
  reg         go_prev_q;
  reg         run_prev_q;
  reg         pready_q;
  reg  [63:0] fn_on;
  reg         fn_set_trip_b;
  integer     i;

  assign pins = {inch_in, forward_run_in, reverse_run_in, prog_in};
  assign pready_out = pready_q;

  // Ready from a flop; every access ends in its first access cycle
  always @(posedge clk_in) begin
    if (!nrst_in)
      pready_q <= 1'b0;
    else
      pready_q <= 1'b1;
  end

  // Half-millisecond tick for the filters
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      div_q  <= 16'h0000;
      tick_q <= 1'b0;
    end else if (div_q == UNIT_CYC[15:0] - 16'h0001) begin
      div_q  <= 16'h0000;
      tick_q <= 1'b1;
    end else begin
      div_q  <= div_q + 16'h0001;
      tick_q <= 1'b0;
    end
  end

  // One filter per terminal
  genvar g;
  generate
    for (g = 0; g < `MFD_NUM_IN; g = g + 1) begin : g_filt
      mfd_input_filter #(
        .UNIT_CYC (UNIT_CYC)
      ) u_filt (
        .clk_in    (clk_in),
        .nrst_in   (nrst_in),
        .tick_in   (tick_q),
        .filt_in   (filt),
        .pin_in    (pins[g]),
        .level_out (lvl[g])
      );
    end
  endgenerate

  // Register block
  mfd_apb_regs u_regs (
    .clk_in       (clk_in),
    .nrst_in      (nrst_in),
    .psel_in      (psel_in),
    .penable_in   (penable_in),
    .pwrite_in    (pwrite_in),
    .paddr_in     (paddr_in),
    .pwdata_in    (pwdata_in),
    .in_state_in  (in_state_q),
    .out_state_in (out_state_q),
    .status_in    ({motor_running_in, ~power_enable_out, trip_out}),
    .prdata_out   (prdata_out),
    .pslverr_out  (pslverr_out),
    .func_sel_out (func_sel),
    .config_out   (cfg),
    .filter_out   (filt),
    .clr_trip_out (clr_trip)
  );

  // Gather which functions are active from the programmable terminals
  always @* begin
    fn_on = 64'h0;
    fn_set_trip_b = 1'b0;
    for (i = 0; i < `MFD_NUM_PROG; i = i + 1) begin
      fn_on[func_sel[i*`MFD_FSEL_W +: `MFD_FSEL_W]] = fn_on[func_sel[i*`MFD_FSEL_W +: `MFD_FSEL_W]] | lvl[i];
      if (func_sel[i*`MFD_FSEL_W +: `MFD_FSEL_W] == `MFD_FN_TRIP_B && !lvl[i])
        fn_set_trip_b = 1'b1;
    end
    fn_on[`MFD_FN_NONE] = 1'b0;
  end

  // Terminal status words
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      in_state_q  <= 9'h000;
      out_state_q <= 4'h0;
    end else begin
      in_state_q  <= lvl;
      out_state_q <= out_pins_in;
    end
  end

  // Trip latch, halt and power enable
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      trip_out         <= 1'b0;
      power_enable_out <= 1'b0;
    end else begin
      if (fn_on[`MFD_FN_TRIP_A] || fn_set_trip_b)
        trip_out <= 1'b1;
      else if (fn_on[`MFD_FN_RESET] || fault_reset_in || clr_trip)
        trip_out <= 1'b0;
      power_enable_out <= ~(fn_on[`MFD_FN_TRIP_A] | fn_set_trip_b | trip_out |
                            fn_on[`MFD_FN_HALT] | emergency_halt_in);
    end
  end

  // Level functions and mode switch-overs
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      integrator_clear_out         <= 1'b0;
      open_loop_out                <= 1'b0;
      local_override_out           <= 1'b0;
      manual_mode_out              <= 1'b0;
      freq_hold_out                <= 1'b0;
      ramp_freeze_out              <= 1'b0;
      alternate_prop_gain_out      <= 1'b0;
      step_hold_out                <= 1'b0;
      traverse_negative_offset_out <= 1'b0;
      traverse_positive_offset_out <= 1'b0;
      run_forward_out              <= 1'b0;
      run_reverse_out              <= 1'b0;
      inch_out                     <= 1'b0;
      current_ref_sel_out          <= 1'b0;
      torque_mode_out              <= 1'b0;
      speed_reg_p_only_out         <= 1'b0;
    end else begin
      integrator_clear_out    <= fn_on[`MFD_FN_ICLEAR];
      ramp_freeze_out         <= fn_on[`MFD_FN_RFREEZE];
      alternate_prop_gain_out <= fn_on[`MFD_FN_PGAIN2];
      freq_hold_out <= fn_on[`MFD_FN_AHOLD] & cfg[`MFD_CFG_ANALOG_REF];
      step_hold_out <= fn_on[`MFD_FN_HOLD_STEP] & cfg[`MFD_CFG_AUTO_EN] & ~cfg[`MFD_CFG_AUTO_B];
      traverse_negative_offset_out <= fn_on[`MFD_FN_TRV_LO] & cfg[`MFD_CFG_TRAVERSE];
      traverse_positive_offset_out <= fn_on[`MFD_FN_TRV_HI] & cfg[`MFD_CFG_TRAVERSE];
      run_forward_out     <= lvl[7] | fn_on[`MFD_FN_FWD];
      run_reverse_out     <= lvl[6] | fn_on[`MFD_FN_REV];
      inch_out            <= lvl[8] | fn_on[`MFD_FN_INCH];
      current_ref_sel_out <= fn_on[`MFD_FN_ANA_CHG];
      torque_mode_out      <= fn_on[`MFD_FN_SPD_TRQ] & cfg[`MFD_CFG_VECTOR];
      speed_reg_p_only_out <= fn_on[`MFD_FN_ASR_PPI] & cfg[`MFD_CFG_VECTOR];
      // Switch-overs held off while the motor turns
      if (!motor_running_in) begin
        open_loop_out      <= fn_on[`MFD_FN_OPEN_LOOP];
        local_override_out <= fn_on[`MFD_FN_LOCAL];
        manual_mode_out    <= fn_on[`MFD_FN_MANUAL];
      end
    end
  end

  // Pre-excitation state left when a run command appears
  always @(posedge clk_in) begin
    if (!nrst_in)
      pre_excite_out <= 1'b0;
    else if (run_forward_out || run_reverse_out)
      pre_excite_out <= 1'b0;
    else if (fn_on[`MFD_FN_PREEXC])
      pre_excite_out <= 1'b1;
  end

  // Step index; inch forces zero index with inch flag
  always @(posedge clk_in) begin
    if (!nrst_in)
      step_index_out <= 4'h0;
    else if (lvl[8] | fn_on[`MFD_FN_INCH])
      step_index_out <= 4'h0;
    else
      step_index_out <= {fn_on[`MFD_FN_SPEED_X], fn_on[`MFD_FN_SPEED_H],
                         fn_on[`MFD_FN_SPEED_M], fn_on[`MFD_FN_SPEED_L]};
  end

  // Sequence selection and stepping
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      sequence_out   <= 3'h0;
      seq_step_out   <= 3'h0;
      seq_active_out <= 1'b0;
      go_prev_q      <= 1'b0;
      run_prev_q     <= 1'b0;
    end else begin
      go_prev_q  <= fn_on[`MFD_FN_GO_STEP];
      run_prev_q <= run_forward_out | run_reverse_out;
      if (!seq_active_out) begin
        seq_step_out <= 3'h0;
        case ({fn_on[`MFD_FN_SEQ_H], fn_on[`MFD_FN_SEQ_M], fn_on[`MFD_FN_SEQ_L]})
          3'h1: sequence_out <= 3'h1;
          3'h2: sequence_out <= 3'h2;
          3'h4: sequence_out <= 3'h3;
          3'h3: sequence_out <= 3'h4;
          3'h5: sequence_out <= 3'h5;
          default: sequence_out <= 3'h0;
        endcase
        // Start only on a fresh run command, so a finished sequence stays stopped
        if (cfg[`MFD_CFG_AUTO_EN] && !manual_mode_out && sequence_out != 3'h0 &&
            (run_forward_out || run_reverse_out) && !run_prev_q && power_enable_out)
          seq_active_out <= 1'b1;
      end else if (!power_enable_out) begin
        seq_active_out <= 1'b0;
      end else if (cfg[`MFD_CFG_AUTO_B] ? (fn_on[`MFD_FN_GO_STEP] & ~go_prev_q)
                                        : seq_step_done_in) begin
        if (seq_step_out == `MFD_SEQ_STEPS - 1) begin
          if (!step_hold_out)
            seq_active_out <= 1'b0;
        end else begin
          seq_step_out <= seq_step_out + 3'h1;
        end
      end
    end
  end
endmodule

// ===== mfd_decoder_chk.sv
// Port checker for the terminal decoder
`include "mfd_defines.vh"
module mfd_decoder_chk (
  input wire logic        clk_in,
  input wire logic        nrst_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic        fault_reset_in,
  input wire logic        emergency_halt_in,
  input wire logic [3:0]  out_pins_in,
  input wire logic        motor_running_in,
  input wire logic        trip_out,
  input wire logic        power_enable_out,
  input wire logic        open_loop_out,
  input wire logic        local_override_out,
  input wire logic        manual_mode_out,
  input wire logic        run_forward_out,
  input wire logic        run_reverse_out,
  input wire logic        pre_excite_out,
  input wire logic        inch_out,
  input wire logic [3:0]  step_index_out
);
  timeunit 1ns;
  timeprecision 1ps;
  wire clr_now;
  wire rd_now;
  // Fault-reset input or a command-register trip clear, and a read access
  assign clr_now = fault_reset_in | (psel_in & penable_in & pwrite_in & (paddr_in == `MFD_OFS_COMMAND) & pwdata_in[0]);
  assign rd_now = psel_in & penable_in & ~pwrite_in;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // Step sequences
  sequence s_tripped; trip_out && $past(trip_out); endsequence
  sequence s_pins_still; $stable(out_pins_in)[*4]; endsequence
  sequence s_run; (run_forward_out || run_reverse_out)[*2]; endsequence
  // Output relations
  property p_trip_cut; s_tripped |-> !power_enable_out; endproperty
  property p_trip_latch; trip_out && !clr_now && !$past(clr_now) && !$past(clr_now, 2) |=> trip_out; endproperty
  property p_out_state; s_pins_still ##0 (rd_now && paddr_in == `MFD_OFS_OUT_STATE) |-> prdata_out == {28'h0000000, out_pins_in}; endproperty
  property p_in_upper; rd_now && paddr_in == `MFD_OFS_IN_STATE |-> prdata_out[31:9] == 23'h000000; endproperty
  property p_halt; emergency_halt_in[*3] |-> !power_enable_out; endproperty
  property p_inch; inch_out && $past(inch_out) |-> step_index_out == 4'h0; endproperty
  property p_mode_hold; motor_running_in && $past(motor_running_in) && $past(motor_running_in, 2)
    |-> $stable(open_loop_out) && $stable(local_override_out) && $stable(manual_mode_out); endproperty
  property p_pre_exc; s_run |-> !pre_excite_out; endproperty
  a_trip_cut: assert property (p_trip_cut)
    else $error("Output enabled while tripped");
  a_trip_latch: assert property (p_trip_latch)
    else $error("Trip released without a clear");
  a_out_state: assert property (p_out_state)
    else $error("Output status word wrong");
  a_in_upper: assert property (p_in_upper)
    else $error("Input status upper bits set");
  a_halt: assert property (p_halt)
    else $error("Output enabled during halt");
  a_inch: assert property (p_inch)
    else $error("Step index not overridden by inch");
  a_mode_hold: assert property (p_mode_hold)
    else $error("Mode changed while running");
  a_pre_exc: assert property (p_pre_exc)
    else $error("Pre-excitation kept during run");
endmodule
bind mfd_decoder mfd_decoder_chk mfd_decoder_chk_i (.clk_in(clk_in), .nrst_in(nrst_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
  .prdata_out(prdata_out), .fault_reset_in(fault_reset_in), .emergency_halt_in(emergency_halt_in),
  .out_pins_in(out_pins_in), .motor_running_in(motor_running_in), .trip_out(trip_out),
  .power_enable_out(power_enable_out), .open_loop_out(open_loop_out), .local_override_out(local_override_out),
  .manual_mode_out(manual_mode_out), .run_forward_out(run_forward_out), .run_reverse_out(run_reverse_out),
  .pre_excite_out(pre_excite_out), .inch_out(inch_out), .step_index_out(step_index_out));

// ===== mfd_switch_strip.sv
// Field switch model for the control terminal strip
module mfd_switch_strip (
  input  wire logic       clk_in,
  input  wire logic [8:0] contact_in,
  input  wire logic       chatter_in,
  output wire logic [8:0] pins_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] level_q = 9'h000;
  // Contacts follow the command; chatter flips every contact each cycle
  always @(posedge clk_in) begin
    level_q <= chatter_in ? ~level_q : contact_in;
  end
  assign pins_out = level_q;
endmodule

// ===== testbench.sv
// Self-checking bench for the terminal decoder
`include "mfd_defines.vh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; $display("Error %0t got %0h exp %0h", $time, a, b); end end
`define F0(c) {14'h0000, `MFD_FN_NONE, `MFD_FN_NONE, c}
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic        psel, penable, pwrite, chatter, fault_reset, halt, running, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, rdata;
  logic [8:0]  contact;
  logic [3:0]  out_pins;
  wire  [31:0] prdata;
  wire  [8:0]  pins;
  wire  [3:0]  step_idx;
  wire  [6:0]  lvl;
  wire         pready, pslverr, trip, power, open_loop, local_ovr, run_f, inch_o, preexc, seq_act, manual, torque;
  wire  [2:0]  seq, seq_step;
  int          n_fail = 0;
  int          n_checks = 0;
  int          cnt, i;
  logic [5:0]  codes [0:6] = '{`MFD_FN_ICLEAR, `MFD_FN_AHOLD, `MFD_FN_RFREEZE, `MFD_FN_PGAIN2,
                              `MFD_FN_ANA_CHG, `MFD_FN_TRV_LO, `MFD_FN_TRV_HI};
  // Clock
  initial forever #12.5 clk_in = ~clk_in;
  mfd_switch_strip mfd_switch_strip_i (.clk_in(clk_in), .contact_in(contact), .chatter_in(chatter), .pins_out(pins));
  mfd_decoder #(.UNIT_CYC(4)) mfd_decoder_i (.clk_in(clk_in), .nrst_in(nrst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .prog_in(pins[5:0]), .reverse_run_in(pins[6]),
    .forward_run_in(pins[7]), .inch_in(pins[8]), .fault_reset_in(fault_reset), .emergency_halt_in(halt),
    .out_pins_in(out_pins), .motor_running_in(running), .seq_step_done_in(1'b0), .trip_out(trip),
    .power_enable_out(power), .integrator_clear_out(lvl[0]), .open_loop_out(open_loop),
    .local_override_out(local_ovr), .freq_hold_out(lvl[1]), .ramp_freeze_out(lvl[2]),
    .alternate_prop_gain_out(lvl[3]), .sequence_out(seq), .seq_step_out(seq_step), .seq_active_out(seq_act),
    .manual_mode_out(manual), .step_hold_out(), .traverse_negative_offset_out(lvl[5]),
    .traverse_positive_offset_out(lvl[6]),
    .run_forward_out(run_f), .run_reverse_out(), .inch_out(inch_o), .current_ref_sel_out(lvl[4]),
    .pre_excite_out(preexc), .torque_mode_out(torque), .speed_reg_p_only_out(), .step_index_out(step_idx));
  // Verdict and end of run
  task summarize;
    if (n_fail == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // One APB transfer, held until pready is sampled high
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    cnt = 0;
    do begin
      @(posedge clk_in);
      cnt++;
    end while (pready !== 1'b1 && cnt < 50);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (cnt >= 50) begin
      n_fail++;
      summarize;
    end
  endtask
  task settle;
    repeat (20) @(posedge clk_in);
  endtask
  // Reset values, read-only and unmapped places
  task t_reset;
    apb(1'b1, `MFD_OFS_IN_STATE, 32'h000001FF);
    apb(1'b0, `MFD_OFS_IN_STATE, 32'h0);
    `CHK(rdata, 32'h00000000)
    apb(1'b0, `MFD_OFS_OUT_STATE, 32'h0);
    `CHK(rdata, 32'h00000000)
    apb(1'b0, `MFD_OFS_FILTER, 32'h0);
    `CHK(rdata, 32'h0000000A)
    apb(1'b0, 12'h020, 32'h0);
    `CHK({err, rdata}, 33'h100000000)
  endtask
  // Chatter is rejected, a clean edge takes the full filter time
  task t_filter;
    chatter <= 1'b1;
    repeat (60) @(posedge clk_in);
    chatter <= 1'b0;
    contact <= 9'h100;
    `CHK(inch_o, 1'b0)
    cnt = 0;
    while (inch_o !== 1'b1 && cnt < 300) begin
      @(posedge clk_in);
      cnt++;
    end
    `CHK(cnt inside {[36:56]}, 1'b1)
    if (cnt >= 300)
      summarize;
    contact <= 9'h000;
    apb(1'b1, `MFD_OFS_FILTER, 32'h00000001);
    settle;
    settle;
  endtask
  // Status words
  task t_status;
    contact <= 9'h1A5;
    out_pins <= 4'hA;
    settle;
    apb(1'b0, `MFD_OFS_IN_STATE, 32'h0);
    `CHK(rdata, 32'h000001A5)
    apb(1'b0, `MFD_OFS_OUT_STATE, 32'h0);
    `CHK(rdata, 32'h0000000A)
    contact <= 9'h000;
    settle;
  endtask
  // Both trip kinds, their clears, and the halt input
  task t_trip;
    apb(1'b1, `MFD_OFS_FUNC_SEL0, `F0(`MFD_FN_TRIP_A));
    contact <= 9'h001;
    settle;
    `CHK({trip, power}, 2'b10)
    contact <= 9'h000;
    settle;
    `CHK(trip, 1'b1)
    apb(1'b1, `MFD_OFS_COMMAND, 32'h00000001);
    settle;
    `CHK({trip, power}, 2'b01)
    contact <= 9'h002;
    settle;
    apb(1'b1, `MFD_OFS_FUNC_SEL0, {14'h0000, `MFD_FN_NONE, `MFD_FN_TRIP_B, `MFD_FN_NONE});
    settle;
    `CHK(trip, 1'b0)
    contact <= 9'h000;
    settle;
    `CHK({trip, power}, 2'b10)
    contact <= 9'h002;
    settle;
    fault_reset <= 1'b1;
    settle;
    fault_reset <= 1'b0;
    `CHK(trip, 1'b0)
    halt <= 1'b1;
    settle;
    `CHK(power, 1'b0)
    halt <= 1'b0;
    settle;
    `CHK(power, 1'b1)
  endtask
  // Every step index, then inch over the highest one
  task t_step;
    apb(1'b1, `MFD_OFS_FUNC_SEL0, {14'h0000, `MFD_FN_SPEED_H, `MFD_FN_SPEED_M, `MFD_FN_SPEED_L});
    apb(1'b1, `MFD_OFS_FUNC_SEL1, `F0(`MFD_FN_SPEED_X));
    for (i = 0; i < 16; i++) begin
      contact <= {5'h00, i[3:0]};
      settle;
      `CHK(step_idx, i[3:0])
    end
    contact <= 9'h10F;
    settle;
    `CHK({inch_o, step_idx}, 5'h10)
    contact <= 9'h000;
    apb(1'b1, `MFD_OFS_FUNC_SEL1, `F0(`MFD_FN_NONE));
  endtask
  // Plain level functions, one function at a time on terminal 0
  task t_levels;
    apb(1'b1, `MFD_OFS_CONFIG, 32'h00000011);
    for (i = 0; i < 7; i++) begin
      apb(1'b1, `MFD_OFS_FUNC_SEL0, `F0(codes[i]));
      contact <= 9'h001;
      settle;
      `CHK(lvl, 7'h01 << i)
      contact <= 9'h000;
      settle;
      `CHK(lvl, 7'h00)
    end
  endtask
  // Mode switch-overs wait for a stop
  task t_mode;
    apb(1'b1, `MFD_OFS_FUNC_SEL0, {14'h0000, `MFD_FN_MANUAL, `MFD_FN_LOCAL, `MFD_FN_OPEN_LOOP});
    running <= 1'b1;
    contact <= 9'h007;
    settle;
    `CHK({open_loop, local_ovr, manual}, 3'b000)
    running <= 1'b0;
    settle;
    `CHK({open_loop, local_ovr, manual}, 3'b111)
    contact <= 9'h000;
    settle;
  endtask
  // Pre-excitation ends on a run command
  task t_preexc;
    apb(1'b1, `MFD_OFS_FUNC_SEL0, `F0(`MFD_FN_PREEXC));
    contact <= 9'h001;
    settle;
    `CHK(preexc, 1'b1)
    contact <= 9'h081;
    settle;
    `CHK({preexc, run_f}, 2'b01)
  endtask
  // Auto-B sequence 4, stepped by go-step, stops after its eighth step
  task t_seq;
    apb(1'b1, `MFD_OFS_CONFIG, 32'h0000000C);
    apb(1'b1, `MFD_OFS_FUNC_SEL0, {14'h0000, `MFD_FN_GO_STEP, `MFD_FN_SEQ_M, `MFD_FN_SEQ_L});
    contact <= 9'h003;
    settle;
    `CHK({seq_act, seq}, 4'h4)
    contact <= 9'h083;
    settle;
    `CHK({seq_act, seq_step}, 4'h8)
    for (i = 1; i < 9; i++) begin
      contact <= 9'h087;
      settle;
      contact <= 9'h083;
      settle;
      `CHK({seq_act, seq_step}, (i < 8) ? (4'h8 | i[3:0]) : 4'h0)
    end
    contact <= 9'h000;
    settle;
  endtask
  // Speed/torque select honoured only under vector control
  task t_vector;
    apb(1'b1, `MFD_OFS_FUNC_SEL0, `F0(`MFD_FN_SPD_TRQ));
    contact <= 9'h001;
    settle;
    `CHK(torque, 1'b0)
    apb(1'b1, `MFD_OFS_CONFIG, 32'h00000002);
    settle;
    `CHK(torque, 1'b1)
    contact <= 9'h000;
    settle;
  endtask
  // Main sequence
  initial begin
    {psel, penable, pwrite, chatter, fault_reset, halt, running} = 7'h00;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    contact = 9'h000;
    out_pins = 4'h0;
    repeat (12) @(posedge clk_in);
    nrst_in <= 1'b1;
    t_reset;
    t_filter;
    t_status;
    t_trip;
    t_step;
    t_levels;
    t_mode;
    t_preexc;
    t_seq;
    t_vector;
    summarize;
  end
endmodule
